// [strap_pkg.sv]
// Package for the reset mode strap sampler: strap bit positions, reset values, timing.
// Assumes a single 250 MHz system clock and an active-low external reset pin input.
package strap_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  // Delay from reset release to the first bus cycle, in system clock output cycles.
  localparam int unsigned FIRST_CYCLE_DELAY_CYCLES = 10;
  localparam logic [3:0] FIRST_CYCLE_COUNT = 4'(FIRST_CYCLE_DELAY_CYCLES);
  // Breakpoint pin must stay low this many cycles before release to count.
  localparam int unsigned BREAK_HOLD_CYCLES = 2;
  localparam logic [1:0] BREAK_HOLD_COUNT = 2'(BREAK_HOLD_CYCLES);

  localparam int unsigned BOOT_WIDTH_BIT = 0;
  localparam int unsigned CS_LOW_GROUP_BIT = 1;
  localparam int unsigned CS_MID_GROUP_BIT = 2;
  localparam int unsigned ADDR_STRAP_LSB = 3;
  localparam int unsigned ADDR_STRAP_MSB = 7;
  localparam int unsigned PORT_E_BIT = 8;
  localparam int unsigned PORT_F_BIT = 9;
  localparam int unsigned RESERVED_MODE_BIT = 11;

  localparam logic [15:0] DATA_PULLUP_VALUE = 16'hffff;
  localparam logic [23:0] BOOT_VECTOR_ADDR = 24'h000000;
  localparam logic [2:0] SUPERVISOR_PROGRAM_FC = 3'h6;
  localparam logic [4:0] ADDR_MODE_RESET = 5'h00;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic boot_16bit;
    logic cs_low_group_sel;
    logic cs_mid_group_sel;
    logic [4:0] addr_line_sel;
    logic port_e_sel;
    logic port_f_sel;
    logic reserved_mode;
    logic synth_clock_sel;
    logic debug_enable;
  } strap_cfg_s;

  localparam strap_cfg_s CFG_DEFAULT = '{1'b1, 1'b1, 1'b1, 5'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

endpackage

// [pin_sync3.sv]
// Three-stage synchroniser with agreement filter for a group of pin inputs.
// Assumes the pins are asynchronous to clk; output moves only when stages two and three agree.
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      pin_sync <= INIT;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_sync[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// [reset_mode_strap_sampler.sv]
// Reset mode strap sampler: samples data bus straps, clock-source and breakpoint pins.
// Assumes reset_pin_n arrives from the board asynchronously; nrst is the chip power reset.
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Data lines pulled up in reset; high is default, low is alternate.
// - First bus cycle starts ten clock cycles after reset release.
// - Boot memory select active straight at reset release.
// - Vector fetch starts at address zero in supervisor program space.
// - Data bit 0 low gives 8-bit boot port, high gives 16-bit.
// - Data bits 1 and 2 low give alternate functions of select groups.
// - Low data bit 7..3 turns its select and lower ones into address lines.
// - Data bit 8 low hands bus control pins to port E.
// - Data bit 9 low hands interrupt pins and clock-mode pin to port F.
// - Clock-mode pin high selects synthesizer, low selects external clock.
// - Breakpoint low at release enables background debug entry on breakpoints.
// - Breakpoint high at release gives normal breakpoint exception processing.
// - Debug enable holds until next reset; relatched each reset release.
// - Breakpoint synchronised; must be low two cycles before release.
// - Module pins come out of reset as port inputs, functions off.
module reset_mode_strap_sampler
  import strap_pkg::*;
(
  // Clock and power reset
  input wire logic clk,
  input wire logic nrst,
  // External reset pin, active low
  input wire logic reset_pin_n,
  // Strap pins
  input wire logic [15:0] data_bus_in,
  input wire logic clock_source_strap,
  input wire logic breakpoint_pin_n,
  // Internal breakpoint request from the processor
  input wire logic internal_breakpoint,
  // Data bus weak pull-up control
  output logic data_pullup_en,
  // Sequencing
  output logic first_bus_cycle,
  output logic boot_memory_select,
  output logic [23:0] vector_fetch_addr,
  output logic [2:0] vector_fetch_fc,
  // Latched configuration
  output strap_cfg_s cfg,
  output logic [4:0] addr_line_mode,
  output logic module_pin_func_en,
  output logic module_port_dir_out,
  // Breakpoint handling
  output logic background_debug_state,
  output logic breakpoint_exception
);

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [15:0] data_sync;
  logic clk_strap_sync;
  logic break_sync_n;
  logic rst_sync_n;

  pin_sync3 #(.WIDTH(16), .INIT(DATA_PULLUP_VALUE)) u_data_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(data_bus_in),
    .pin_sync(data_sync)
  );

  pin_sync3 #(.WIDTH(3), .INIT(3'h6)) u_ctl_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in({clock_source_strap, breakpoint_pin_n, reset_pin_n}),
    .pin_sync({clk_strap_sync, break_sync_n, rst_sync_n})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  seq_state_e state_reg;
  logic [3:0] wait_cnt_reg;
  logic [1:0] break_low_cnt_reg;
  logic break_prev_n_reg;

  // Thermometer: a low strap on bit k drives address lines for selects 0..k.
  function automatic logic [4:0] addr_thermo(input logic [4:0] straps_n);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 0; k < 5; k++) begin
      for (int j = k; j < 5; j++) begin
        if (!straps_n[j]) begin
          r[k] = 1'b1;
        end
      end
    end
    return r;
  endfunction

  // The wait counter stops at its end value and the machine then leaves the wait.
  // A reset that returns during the wait sends the machine back to sample again.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_RESET;
      wait_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_RESET: begin
          wait_cnt_reg <= 4'h0;
          if (rst_sync_n) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!rst_sync_n) begin
            state_reg <= ST_RESET;
          end else if (wait_cnt_reg == FIRST_CYCLE_COUNT - 4'h1) begin
            state_reg <= ST_RUN;
          end else begin
            wait_cnt_reg <= wait_cnt_reg + 4'h1;
          end
        end
        ST_RUN: begin
          if (!rst_sync_n) begin
            state_reg <= ST_RESET;
          end
        end
        default: begin
          state_reg <= ST_RESET;
        end
      endcase
    end
  end

  // Breakpoint low count during reset; two cycles low qualifies debug entry.
  // The count saturates, so a pin held low through a long reset still qualifies.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      break_low_cnt_reg <= 2'h0;
    end else if (state_reg == ST_RESET) begin
      if (break_sync_n) begin
        break_low_cnt_reg <= 2'h0;
      end else if (break_low_cnt_reg != BREAK_HOLD_COUNT) begin
        break_low_cnt_reg <= break_low_cnt_reg + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration latch

  // Captured on the release edge only, so board drivers may let go afterwards.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= CFG_DEFAULT;
      addr_line_mode <= ADDR_MODE_RESET;
    end else if (state_reg == ST_RESET && rst_sync_n) begin
      cfg.boot_16bit <= data_sync[BOOT_WIDTH_BIT];
      cfg.cs_low_group_sel <= data_sync[CS_LOW_GROUP_BIT];
      cfg.cs_mid_group_sel <= data_sync[CS_MID_GROUP_BIT];
      cfg.addr_line_sel <= ~data_sync[ADDR_STRAP_MSB:ADDR_STRAP_LSB];
      addr_line_mode <= addr_thermo(data_sync[ADDR_STRAP_MSB:ADDR_STRAP_LSB]);
      cfg.port_e_sel <= ~data_sync[PORT_E_BIT];
      cfg.port_f_sel <= ~data_sync[PORT_F_BIT];
      cfg.reserved_mode <= ~data_sync[RESERVED_MODE_BIT];
      cfg.synth_clock_sel <= clk_strap_sync;
      cfg.debug_enable <= (break_low_cnt_reg == BREAK_HOLD_COUNT) && !break_sync_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // The vector and module pin outputs never change, but they are registered anyway
  // so that every output of the block comes straight from a flip-flop.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_pullup_en <= 1'b1;
      boot_memory_select <= 1'b0;
      first_bus_cycle <= 1'b0;
      vector_fetch_addr <= BOOT_VECTOR_ADDR;
      vector_fetch_fc <= SUPERVISOR_PROGRAM_FC;
      module_pin_func_en <= 1'b0;
      module_port_dir_out <= 1'b0;
    end else begin
      data_pullup_en <= (state_reg == ST_RESET);
      boot_memory_select <= (state_reg != ST_RESET) || rst_sync_n;
      first_bus_cycle <= (state_reg == ST_WAIT) && rst_sync_n &&
                         (wait_cnt_reg == FIRST_CYCLE_COUNT - 4'h1);
      vector_fetch_addr <= BOOT_VECTOR_ADDR;
      vector_fetch_fc <= SUPERVISOR_PROGRAM_FC;
      module_pin_func_en <= 1'b0;
      module_port_dir_out <= 1'b0;
    end
  end

  // Breakpoint edges in the run state, from the first bus cycle on, go to debug or the normal exception path.
  // Only the falling edge of the pin acts, so a pin held low raises one request.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      break_prev_n_reg <= 1'b1;
      background_debug_state <= 1'b0;
      breakpoint_exception <= 1'b0;
    end else begin
      break_prev_n_reg <= break_sync_n;
      breakpoint_exception <= 1'b0;
      if (state_reg == ST_RESET) begin
        background_debug_state <= 1'b0;
      end else if (state_reg == ST_RUN &&
                   ((break_prev_n_reg && !break_sync_n) || internal_breakpoint)) begin
        if (cfg.debug_enable) begin
          background_debug_state <= 1'b1;
        end else begin
          breakpoint_exception <= 1'b1;
        end
      end
    end
  end

endmodule

// [strap_assertions.sv]
// Checker for the strap sampler, seeing only its ports.
// Assumes the bind at the foot reaches every sampler instance.
`timescale 1ns/100ps
module strap_assertions
  import strap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched outputs
  input wire logic data_pullup_en,
  input wire logic first_bus_cycle,
  input wire logic boot_memory_select,
  input wire logic [23:0] vector_fetch_addr,
  input wire logic [2:0] vector_fetch_fc,
  input wire strap_cfg_s cfg,
  input wire logic [4:0] addr_line_mode,
  input wire logic module_pin_func_en,
  input wire logic module_port_dir_out,
  input wire logic background_debug_state,
  input wire logic breakpoint_exception
);
  logic [4:0] sel;
  assign sel = cfg.addr_line_sel;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_release;
    $fell(data_pullup_en);
  endsequence
  sequence s_ten_cycles;
    (!first_bus_cycle)[*8] ##1 first_bus_cycle;
  endsequence
  a_first_cycle_ten: assert property (s_release |=> s_ten_cycles)
    else $error("first bus cycle off ten");
  a_pulse_single: assert property (first_bus_cycle |=> !first_bus_cycle)
    else $error("bus cycle pulse too long");
  a_boot_at_release: assert property (s_release |-> boot_memory_select)
    else $error("boot select late");
  a_pullup_in_reset: assert property (!data_pullup_en |-> boot_memory_select)
    else $error("pull-up off in reset");
  a_pullup_overlap: assert property (data_pullup_en && boot_memory_select |=>
    !data_pullup_en)
    else $error("pull-up held after release");
  a_vector_start: assert property (vector_fetch_addr == BOOT_VECTOR_ADDR
    && vector_fetch_fc == SUPERVISOR_PROGRAM_FC)
    else $error("vector fetch wrong");
  a_pins_input: assert property (!module_pin_func_en && !module_port_dir_out)
    else $error("module pins not inputs");
  a_cfg_held: assert property (!data_pullup_en && !$past(data_pullup_en) |-> $stable(cfg))
    else $error("cfg moved");
  a_addr_thermo: assert property (!data_pullup_en |->
    addr_line_mode == (sel | sel >> 1 | sel >> 2 | sel >> 3 | sel >> 4))
    else $error("address line mode wrong");
  a_break_exception: assert property (breakpoint_exception |-> !cfg.debug_enable)
    else $error("exception with debug on");
  a_debug_entry: assert property ($rose(background_debug_state) |-> cfg.debug_enable)
    else $error("debug entered while off");
  a_debug_holds: assert property (background_debug_state |=>
    background_debug_state || data_pullup_en)
    else $error("debug state dropped");
endmodule
bind reset_mode_strap_sampler strap_assertions u_chk (.clk, .nrst, .data_pullup_en,
  .first_bus_cycle, .boot_memory_select, .vector_fetch_addr, .vector_fetch_fc, .cfg,
  .addr_line_mode, .module_pin_func_en, .module_port_dir_out, .background_debug_state,
  .breakpoint_exception);

// [strap_board_model.sv]
// Board strap conditioning model for the sampler's pins.
// Assumes the sampler's pull-up flag marks the mode-select window.
`timescale 1ns/100ps
module strap_board_model (
  // Clock and window flag
  input wire logic clk,
  input wire logic data_pullup_en,
  // Requested straps
  input wire logic [15:0] strap_lows_n,
  input wire logic clock_strap_level,
  input wire logic break_low,
  // Breakpoint request after release
  input wire logic break_run,
  // Pins
  output logic [15:0] data_bus_in,
  output logic clock_source_strap,
  output logic breakpoint_pin_n
);
  logic [15:0] junk_reg = 16'h1234;
  // A free bus shows a moving pattern, so stale strap values cannot pass by luck.
  always @(posedge clk) begin
    junk_reg <= junk_reg + 16'h3c5b;
  end
  // Data and breakpoint strap drivers act only inside the reset window, when no transfer is in flight.
  assign data_bus_in = data_pullup_en ? (strap_lows_n | 16'h0800) : junk_reg;
  assign clock_source_strap = clock_strap_level;
  assign breakpoint_pin_n = !((break_low && data_pullup_en) || break_run);
endmodule

// [tb.sv]
// Testbench for the strap sampler with the board model on its pins.
// Assumes the package, synchroniser and sampler compile ahead of it.
`timescale 1ns/100ps
module tb;
  import strap_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reset_pin_n = 1'b0;
  logic internal_breakpoint = 1'b0;
  logic [15:0] strap_lows_n = 16'hffff;
  logic clock_strap_level = 1'b1;
  logic break_low = 1'b0;
  logic break_run = 1'b0;
  logic [15:0] data_bus_in;
  logic clock_source_strap, breakpoint_pin_n, data_pullup_en, first_bus_cycle;
  logic boot_memory_select, module_pin_func_en, module_port_dir_out;
  logic background_debug_state, breakpoint_exception;
  logic [23:0] vector_fetch_addr;
  logic [2:0] vector_fetch_fc;
  logic [4:0] addr_line_mode;
  strap_cfg_s cfg;
  int fail_count = 0;
  int n_compared = 0;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  strap_board_model u_board (.clk, .data_pullup_en, .strap_lows_n, .clock_strap_level,
    .break_low, .break_run, .data_bus_in, .clock_source_strap, .breakpoint_pin_n);
  reset_mode_strap_sampler DUT (.clk, .nrst, .reset_pin_n, .data_bus_in,
    .clock_source_strap, .breakpoint_pin_n, .internal_breakpoint, .data_pullup_en,
    .first_bus_cycle, .boot_memory_select, .vector_fetch_addr, .vector_fetch_fc, .cfg,
    .addr_line_mode, .module_pin_func_en, .module_port_dir_out,
    .background_debug_state, .breakpoint_exception);
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic check_cfg(input strap_cfg_s got, input strap_cfg_s exp);
    check_val(24'(got), 24'(exp), "cfg differs");
  endtask
  // Boots with the given straps and checks timing and the latched configuration.
  task automatic boot(input logic [15:0] lows_n, input logic clk_strap, input logic dbg);
    int n;
    logic [4:0] s;
    strap_lows_n = lows_n;
    clock_strap_level = clk_strap;
    break_low = dbg;
    reset_pin_n = 1'b0;
    repeat (8) @(negedge clk);
    check_bit(data_pullup_en, 1'b1, "pull-up off in reset");
    reset_pin_n = 1'b1;
    for (n = 0; data_pullup_en !== 1'b0; n++) begin
      @(negedge clk);
      if (n > 20) begin
        check_bit(1'b0, 1'b1, "no release");
        report_and_stop();
      end
    end
    check_bit(boot_memory_select, 1'b1, "boot select late");
    for (n = 0; n < 9; n++) begin
      check_bit(first_bus_cycle, 1'b0, "early bus cycle");
      @(negedge clk);
    end
    check_bit(first_bus_cycle, 1'b1, "bus cycle not at ten");
    @(negedge clk);
    s = ~lows_n[7:3];
    check_cfg(cfg, '{lows_n[0], lows_n[1], lows_n[2], s, ~lows_n[8], ~lows_n[9],
      1'b0, clk_strap, dbg});
    check_val(24'(addr_line_mode), 24'(s | s >> 1 | s >> 2 | s >> 3 | s >> 4), "addr");
    check_val(vector_fetch_addr, BOOT_VECTOR_ADDR, "vector address");
    check_val(24'(vector_fetch_fc), 24'(SUPERVISOR_PROGRAM_FC), "vector space");
    check_val(24'({module_pin_func_en, module_port_dir_out}), 24'h000000, "module pins");
  endtask
  task automatic scen_strap_table();
    boot(16'hffff, 1'b1, 1'b0);
    for (int b = 0; b < 10; b++) begin
      boot(~(16'h0001 << b), 1'b1, 1'b0);
    end
    boot(16'hff5f, 1'b0, 1'b0);
  endtask
  // Raises one breakpoint, internal or from the pin, and checks both responses.
  task automatic scen_breakpoint(input logic dbg, input logic use_pin);
    int n;
    boot(16'hffff, 1'b1, dbg);
    if (use_pin) begin
      break_run = 1'b1;
    end else begin
      internal_breakpoint = 1'b1;
    end
    for (n = 0; n < 12 && (background_debug_state | breakpoint_exception) !== 1'b1; n++) begin
      @(negedge clk);
      internal_breakpoint = 1'b0;
    end
    check_bit(background_debug_state, dbg, "debug entry");
    check_bit(breakpoint_exception, !dbg, "exception pulse");
    @(negedge clk);
    break_run = 1'b0;
    check_bit(breakpoint_exception, 1'b0, "exception too long");
    check_bit(background_debug_state, dbg, "debug held");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    scen_strap_table();
    scen_breakpoint(1'b1, 1'b0);
    scen_breakpoint(1'b0, 1'b0);
    scen_breakpoint(1'b1, 1'b1);
    scen_breakpoint(1'b0, 1'b1);
    report_and_stop();
  end
endmodule
